/* sivw_pkg.sv */
// shared constants for the serial interrupt vector and wait/ready block
`default_nettype none
package sivw_pkg;
    // register pointer values, command code and their fields
    localparam logic [2:0] SIVW_PTR_CMD = 3'h0;
    localparam logic [2:0] SIVW_PTR_CTRL = 3'h1;
    localparam logic [2:0] SIVW_PTR_VEC = 3'h2;
    localparam int SIVW_PTR_LSB = 0;
    localparam int SIVW_CMD_LSB = 3;
    localparam logic [2:0] SIVW_CMD_CHAN_RESET = 3'h3;
    // control register field positions
    localparam int SIVW_EXT_EN_BIT = 0;
    localparam int SIVW_TX_EN_BIT = 1;
    localparam int SIVW_SAV_BIT = 2;
    localparam int SIVW_RXM_LSB = 3;
    localparam int SIVW_WR_BUF_BIT = 5;
    localparam int SIVW_WR_FUNC_BIT = 6;
    localparam int SIVW_WR_EN_BIT = 7;
    // receive interrupt modes
    localparam logic [1:0] SIVW_RXM_OFF = 2'h0;
    localparam logic [1:0] SIVW_RXM_FIRST = 2'h1;
    localparam logic [1:0] SIVW_RXM_ALL = 2'h2;
    localparam logic [1:0] SIVW_RXM_NOPAR = 2'h3;
    // reset values
    localparam logic [7:0] SIVW_CTRL_RST = 8'h00;
    localparam logic [7:0] SIVW_VEC_RST = 8'h00;
    // cause codes, channel B; channel A adds the high bit
    localparam logic [1:0] SIVW_CAUSE_TX = 2'h0;
    localparam logic [1:0] SIVW_CAUSE_EXT = 2'h1;
    localparam logic [1:0] SIVW_CAUSE_RX = 2'h2;
    localparam logic [1:0] SIVW_CAUSE_SPC = 2'h3;
endpackage
`default_nettype wire

/* sivw_core.sv */
// interrupt source selection, vector generation and wait/ready control
// Functional notes
// - ext/status enable: break, input change, underrun
// - tx enable: interrupt when transmit buffer empties
// - status-affects-vector replaces vector bits 1..3
// - status-affects-vector exists only in channel B
// - two-bit receive interrupt mode selects behaviour
// - mode 11 excludes parity error from special
// - specials: overrun, parity, framing, SDLC end-of-frame
// - buffer select: 1 receive, 0 transmit
// - function select: 1 ready, 0 wait
// - pin driven only while enable bit set
// - ready on transmit: high full, low empty
// - wait on transmit: low full and addressed
// - receive: wait low empty addressed; ready inverse
// - vector register holds 8-bit acknowledge vector
// - modification leaves stored vector unchanged
// - cause codes B 000..011, A 100..111
// - request state frozen during opcode-fetch acknowledge
// - pointer returns to zero after each access
`default_nettype none
module sivw_core
    import sivw_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // command port, one write strobe plus a channel select from the host bus
    input wire logic cmd_wr_i,
    input wire logic cmd_chan_a_i,
    input wire logic [7:0] cmd_data_i,
    // channel status, index 0 = B, 1 = A
    input wire logic [1:0] brk_abort_i,
    input wire logic [1:0] dcd_i,
    input wire logic [1:0] cts_i,
    input wire logic [1:0] sync_i,
    input wire logic [1:0] underrun_eom_i,
    input wire logic [1:0] tx_empty_i,
    input wire logic [1:0] rx_avail_i,
    input wire logic [1:0] rx_overrun_i,
    input wire logic [1:0] rx_parity_i,
    input wire logic [1:0] rx_framing_i,
    input wire logic [1:0] rx_eof_i,
    input wire logic [1:0] sdlc_mode_i,
    input wire logic [1:0] first_char_i,
    input wire logic [1:0] data_sel_i,
    // processor acknowledge side
    input wire logic opcode_fetch_ack_n_i,
    input wire logic int_ack_i,
    // outputs
    output logic [1:0] int_req_o,
    output logic [7:0] vector_o,
    output logic [1:0] wait_ready_o,
    output logic [1:0] wait_ready_oe_o,
    output logic [2:0] ptr_o
);
    // write-only control registers, index 0 = B, 1 = A
    logic [7:0] ctrl_reg [2];
    // vector byte; lives in channel B only
    logic [7:0] vec_reg;
    // register pointer and the channel it was set from
    logic [2:0] ptr_reg;
    logic ptr_a_reg;
    // one-cycle channel reset strobes
    logic [1:0] chan_rst;
    // status parity: two sync stages, then the edge register
    logic [1:0] ext_s1, ext_s2, ext_d;
    // delayed buffer levels for edge detection
    logic [1:0] tx_d, rx_d;
    // per-cycle interrupt causes, before latching
    logic [1:0] ext_hit, tx_hit, rx_hit, spc_hit;
    // latched causes, cleared by acknowledge or reset
    logic [1:0] ext_pend, tx_pend, rx_pend, spc_pend;
    logic [1:0] int_req_next;
    // status-affects-vector, channel B bit only
    logic sav;
    // winning cause: channel in bit 2, code below
    logic [2:0] cause_next;

    // channel reset command seen on a pointer-zero write
    always_comb begin
        chan_rst = 2'h0;
        if (cmd_wr_i && ptr_reg == SIVW_PTR_CMD
                && cmd_data_i[SIVW_CMD_LSB +: 3] == SIVW_CMD_CHAN_RESET) begin
            chan_rst[cmd_chan_a_i] = 1'b1;
        end
    end

    // pointer: set on command write, back to zero after any access
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ptr_reg <= SIVW_PTR_CMD;
            ptr_a_reg <= 1'b0;
        end else if (cmd_wr_i) begin
            if (ptr_reg == SIVW_PTR_CMD) begin
                ptr_reg <= cmd_data_i[SIVW_PTR_LSB +: 3];
                ptr_a_reg <= cmd_chan_a_i;
            end else begin
                ptr_reg <= SIVW_PTR_CMD;
            end
        end
    end
    assign ptr_o = ptr_reg;

    // per-channel control and event detection
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            logic [4:0] ev;
            logic par_ok;
            assign ev = {brk_abort_i[c], dcd_i[c], cts_i[c], sync_i[c],
                         underrun_eom_i[c]};
            // control register, cleared by reset and channel reset
            always_ff @(posedge clock_i) begin
                if (!rst_n_i || chan_rst[c]) begin
                    ctrl_reg[c] <= SIVW_CTRL_RST;
                end else if (cmd_wr_i && ptr_reg == SIVW_PTR_CTRL
                        && cmd_chan_a_i == ptr_a_reg && ptr_a_reg == c) begin
                    ctrl_reg[c] <= cmd_data_i;
                end
            end
            // status pins are external, synchronise before use
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    ext_s1[c] <= 1'b0;
                    ext_s2[c] <= 1'b0;
                end else begin
                    ext_s1[c] <= ^ev;
                    ext_s2[c] <= ext_s1[c];
                end
            end
            // edge detectors on internal buffer status and the synchronised status parity
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    tx_d[c] <= 1'b1;
                    rx_d[c] <= 1'b0;
                    ext_d[c] <= 1'b0;
                end else begin
                    tx_d[c] <= tx_empty_i[c];
                    rx_d[c] <= rx_avail_i[c];
                    ext_d[c] <= ext_s2[c];
                end
            end
            // a change in the parity of the status set is an ext/status event
            assign ext_hit[c] = ctrl_reg[c][SIVW_EXT_EN_BIT]
                && (ext_s2[c] != ext_d[c]);
            assign tx_hit[c] = ctrl_reg[c][SIVW_TX_EN_BIT]
                && tx_empty_i[c] && !tx_d[c];
            // parity ignored only in the no-parity mode
            assign par_ok = rx_parity_i[c]
                && ctrl_reg[c][SIVW_RXM_LSB +: 2] != SIVW_RXM_NOPAR;
            assign spc_hit[c] = ctrl_reg[c][SIVW_RXM_LSB +: 2] != SIVW_RXM_OFF
                && (rx_overrun_i[c] || par_ok || rx_framing_i[c]
                    || (rx_eof_i[c] && sdlc_mode_i[c]));
            always_comb begin
                unique case (ctrl_reg[c][SIVW_RXM_LSB +: 2])
                    SIVW_RXM_OFF: rx_hit[c] = 1'b0;
                    SIVW_RXM_FIRST: rx_hit[c] = rx_avail_i[c] && !rx_d[c]
                        && first_char_i[c];
                    SIVW_RXM_ALL, SIVW_RXM_NOPAR:
                        rx_hit[c] = rx_avail_i[c] && !rx_d[c];
                endcase
            end
            // pending flags; set wins over acknowledge clear; frozen
            // while opcode-fetch acknowledge is active
            always_ff @(posedge clock_i) begin
                if (!rst_n_i || chan_rst[c]) begin
                    ext_pend[c] <= 1'b0;
                    tx_pend[c] <= 1'b0;
                    rx_pend[c] <= 1'b0;
                    spc_pend[c] <= 1'b0;
                end else if (opcode_fetch_ack_n_i) begin
                    ext_pend[c] <= ext_hit[c] || (ext_pend[c]
                        && !(int_ack_i && cause_next[2] == c
                        && cause_next[1:0] == SIVW_CAUSE_EXT));
                    tx_pend[c] <= tx_hit[c] || (tx_pend[c]
                        && !(int_ack_i && cause_next[2] == c
                        && cause_next[1:0] == SIVW_CAUSE_TX));
                    rx_pend[c] <= rx_hit[c] || (rx_pend[c]
                        && !(int_ack_i && cause_next[2] == c
                        && cause_next[1:0] == SIVW_CAUSE_RX));
                    spc_pend[c] <= spc_hit[c] || (spc_pend[c]
                        && !(int_ack_i && cause_next[2] == c
                        && cause_next[1:0] == SIVW_CAUSE_SPC));
                end
            end
            assign int_req_next[c] = ext_pend[c] || tx_pend[c]
                || rx_pend[c] || spc_pend[c];

            // wait/ready pin per channel; 1 = ready/high
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    wait_ready_o[c] <= 1'b1;
                    wait_ready_oe_o[c] <= 1'b0;
                end else if (!ctrl_reg[c][SIVW_WR_EN_BIT]) begin
                    wait_ready_o[c] <= 1'b1;
                    wait_ready_oe_o[c] <= 1'b0;
                end else if (ctrl_reg[c][SIVW_WR_FUNC_BIT]) begin
                    // ready drives always
                    wait_ready_oe_o[c] <= 1'b1;
                    if (ctrl_reg[c][SIVW_WR_BUF_BIT]) begin
                        wait_ready_o[c] <= !rx_avail_i[c];
                    end else begin
                        wait_ready_o[c] <= !tx_empty_i[c];
                    end
                end else begin
                    // wait only pulls low, floats otherwise
                    wait_ready_o[c] <= 1'b0;
                    if (ctrl_reg[c][SIVW_WR_BUF_BIT]) begin
                        wait_ready_oe_o[c] <= !rx_avail_i[c]
                            && data_sel_i[c];
                    end else begin
                        wait_ready_oe_o[c] <= !tx_empty_i[c]
                            && data_sel_i[c];
                    end
                end
            end
        end
    endgenerate

    // vector register, written on channel B pointer only
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            vec_reg <= SIVW_VEC_RST;
        end else if (cmd_wr_i && ptr_reg == SIVW_PTR_VEC
                && !ptr_a_reg && !cmd_chan_a_i) begin
            vec_reg <= cmd_data_i;
        end
    end

    // status-affects-vector taken from channel B only
    assign sav = ctrl_reg[0][SIVW_SAV_BIT];

    // highest priority cause: channel A first, special, rx, tx, ext
    // the same choice picks the flag an acknowledge clears, but vector_o
    // shows the choice of the cycle before, so the two differ when it has just changed
    always_comb begin
        cause_next = {1'b0, SIVW_CAUSE_TX};
        if (spc_pend[1]) cause_next = {1'b1, SIVW_CAUSE_SPC};
        else if (rx_pend[1]) cause_next = {1'b1, SIVW_CAUSE_RX};
        else if (tx_pend[1]) cause_next = {1'b1, SIVW_CAUSE_TX};
        else if (ext_pend[1]) cause_next = {1'b1, SIVW_CAUSE_EXT};
        else if (spc_pend[0]) cause_next = {1'b0, SIVW_CAUSE_SPC};
        else if (rx_pend[0]) cause_next = {1'b0, SIVW_CAUSE_RX};
        else if (tx_pend[0]) cause_next = {1'b0, SIVW_CAUSE_TX};
        else if (ext_pend[0]) cause_next = {1'b0, SIVW_CAUSE_EXT};
    end

    // outputs registered; stored vector never touched by the merge
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            int_req_o <= 2'h0;
            vector_o <= SIVW_VEC_RST;
        end else begin
            int_req_o <= int_req_next;
            if (sav) begin
                vector_o <= {vec_reg[7:4], cause_next, vec_reg[0]};
            end else begin
                vector_o <= vec_reg;
            end
        end
    end

    // assertions
    // all checks run on the one system clock and are muted in reset;
    // antecedents that name a pending flag also exclude a channel
    // reset or a frozen fetch cycle, which legally override the set
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    vec_plain_a: assert property (!sav |=> vector_o == $past(vec_reg))
        else $error("vector not stored byte");
    vec_cause_a: assert property (sav |=> vector_o[3:1] == $past(cause_next)
        && vector_o[7:4] == $past(vec_reg[7:4]))
        else $error("vector cause bits wrong");
    wr_off_a: assert property (!ctrl_reg[0][SIVW_WR_EN_BIT]
        |=> !wait_ready_oe_o[0])
        else $error("wait pin driven while disabled");
    rdy_tx_a: assert property (ctrl_reg[0][7:5] == 3'h6
        |=> wait_ready_oe_o[0] && wait_ready_o[0] == !$past(tx_empty_i[0]))
        else $error("ready on transmit wrong");
    wait_tx_a: assert property (ctrl_reg[0][7:5] == 3'h4 && tx_empty_i[0]
        |=> !wait_ready_oe_o[0])
        else $error("wait must float on empty");
    wait_rx_a: assert property (ctrl_reg[0][7:5] == 3'h5 && !rx_avail_i[0]
        && data_sel_i[0] |=> wait_ready_oe_o[0] && !wait_ready_o[0])
        else $error("wait on receive wrong");
    freeze_a: assert property (!opcode_fetch_ack_n_i
        |=> $stable(ext_pend) && $stable(rx_pend) && $stable(tx_pend)
        && $stable(spc_pend))
        else $error("request changed during fetch acknowledge");
    tx_int_a: assert property (ctrl_reg[0][SIVW_TX_EN_BIT] && tx_empty_i[0]
        && !tx_d[0] && opcode_fetch_ack_n_i && !chan_rst[0]
        |=> ##1 int_req_o[0])
        else $error("transmit empty raised no request");
    ptr_ret_a: assert property (cmd_wr_i && ptr_reg != SIVW_PTR_CMD
        |=> ptr_reg == SIVW_PTR_CMD)
        else $error("pointer not returned");
    rst_clr_a: assert property (chan_rst[0] |=> ctrl_reg[0] == SIVW_CTRL_RST)
        else $error("channel reset left enables");
    nopar_a: assert property (ctrl_reg[0][4:3] == SIVW_RXM_NOPAR
        && !rx_overrun_i[0] && !rx_framing_i[0] && !rx_eof_i[0]
        |-> !spc_hit[0])
        else $error("parity counted as special");
    sav_b_a: assert property (ctrl_reg[1][SIVW_SAV_BIT]
        && !ctrl_reg[0][SIVW_SAV_BIT] |=> vector_o == $past(vec_reg))
        else $error("channel A bit modified vector");

    // wait/ready table rows not covered above
    rdy_rx_a: assert property (ctrl_reg[0][7:5] == 3'h7
        |=> wait_ready_oe_o[0]
        && wait_ready_o[0] == !$past(rx_avail_i[0]))
        else $error("ready on receive wrong");
    wait_full_a: assert property (ctrl_reg[0][7:5] == 3'h4
        && !tx_empty_i[0] && data_sel_i[0]
        |=> wait_ready_oe_o[0] && !wait_ready_o[0])
        else $error("wait on full transmit wrong");

    // cause latching and stored vector
    spc_set_a: assert property (ctrl_reg[0][4:3] != SIVW_RXM_OFF
        && rx_overrun_i[0] && opcode_fetch_ack_n_i && !chan_rst[0]
        |=> spc_pend[0])
        else $error("overrun not latched as special");
    ext_set_a: assert property (ext_hit[1] && opcode_fetch_ack_n_i
        && !chan_rst[1] |=> ext_pend[1])
        else $error("status change not latched");
    rx_first_a: assert property (ctrl_reg[0][4:3] == SIVW_RXM_FIRST
        && !first_char_i[0] |-> !rx_hit[0])
        else $error("later character interrupted");
    vec_keep_a: assert property (sav && !cmd_wr_i
        |=> vec_reg == $past(vec_reg))
        else $error("stored vector altered");

    cov_sav_c: cover property (sav && int_ack_i && int_req_o[1]);
    cov_ready_c: cover property (wait_ready_oe_o[1] && wait_ready_o[1]);
    cov_spc_c: cover property (spc_pend[0] && rx_pend[0]);
    cov_freeze_c: cover property (!opcode_fetch_ack_n_i && tx_hit[0]);
    cov_wait_c: cover property (wait_ready_oe_o[0] && !wait_ready_o[0]);
endmodule
`default_nettype wire

/* sivw_host_model.sv */
// host bus partner: command port writes and interrupt acknowledge
`default_nettype none
module sivw_host_model (
    // clock
    input wire logic clock_i,
    // command port and acknowledge toward the block
    output logic cmd_wr_o,
    output logic cmd_chan_a_o,
    output logic [7:0] cmd_data_o,
    output logic int_ack_o,
    output logic fetch_ack_n_o,
    // vector coming back
    input wire logic [7:0] vector_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet bus from time zero
    initial begin
        cmd_wr_o = 1'b0;
        cmd_chan_a_o = 1'b0;
        cmd_data_o = 8'h00;
        int_ack_o = 1'b0;
        fetch_ack_n_o = 1'b1;
    end
    // all strobes move just after a rising edge
    task automatic after_edge();
        @(posedge clock_i);
        #1;
    endtask
    // one byte, held until the edge that takes it
    task automatic put_byte(input logic chan_a, input logic [7:0] val);
        after_edge();
        cmd_wr_o = 1'b1;
        cmd_chan_a_o = chan_a;
        cmd_data_o = val;
    endtask
    // released data is inverted so a stale byte never looks valid
    task automatic release_bus();
        after_edge();
        cmd_wr_o = 1'b0;
        cmd_data_o = ~cmd_data_o;
    endtask
    // pointer byte first, then exactly one register byte
    task automatic write_reg(input logic chan_a, input logic [2:0] ptr,
                             input logic [7:0] val);
        put_byte(chan_a, {5'h00, ptr});
        put_byte(chan_a, val);
        release_bus();
    endtask
    task automatic write_cmd(input logic chan_a, input logic [7:0] val);
        put_byte(chan_a, val);
        release_bus();
    endtask
    // vector is read while the acknowledge is held
    task automatic acknowledge(output logic [7:0] vec);
        after_edge();
        int_ack_o = 1'b1;
        vec = vector_i;
        after_edge();
        int_ack_o = 1'b0;
    endtask
    task automatic set_fetch(input logic level_n);
        after_edge();
        fetch_ack_n_o = level_n;
    endtask
endmodule
`default_nettype wire

/* test_serial_irq_vector_waitready.sv */
// self-checking bench for interrupt vector and wait/ready control
`default_nettype none
module test_serial_irq_vector_waitready
    import sivw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_wr, cmd_a, int_ack, fetch_n;
    logic [7:0] cmd_data, vec, got;
    logic [4:0] ext_a = 5'h00, ext_b = 5'h00;
    logic [3:0] spc_a = 4'h0, spc_b = 4'h0;
    logic [1:0] txe = 2'h0, rxa = 2'h0, sdlc = 2'h0, first = 2'h0;
    logic [1:0] sel = 2'h0, req, pin, oe;
    logic [2:0] ptr;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    // 50 ns clock
    always #25 clock_i = ~clock_i;
    sivw_host_model host (.clock_i(clock_i), .cmd_wr_o(cmd_wr),
        .cmd_chan_a_o(cmd_a), .cmd_data_o(cmd_data), .int_ack_o(int_ack),
        .fetch_ack_n_o(fetch_n), .vector_i(vec));
    sivw_core dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_wr_i(cmd_wr),
        .cmd_chan_a_i(cmd_a), .cmd_data_i(cmd_data),
        .brk_abort_i({ext_a[0], ext_b[0]}), .dcd_i({ext_a[1], ext_b[1]}),
        .cts_i({ext_a[2], ext_b[2]}), .sync_i({ext_a[3], ext_b[3]}),
        .underrun_eom_i({ext_a[4], ext_b[4]}), .tx_empty_i(txe),
        .rx_avail_i(rxa), .rx_overrun_i({spc_a[0], spc_b[0]}),
        .rx_parity_i({spc_a[1], spc_b[1]}),
        .rx_framing_i({spc_a[2], spc_b[2]}), .rx_eof_i({spc_a[3], spc_b[3]}),
        .sdlc_mode_i(sdlc), .first_char_i(first), .data_sel_i(sel),
        .opcode_fetch_ack_n_i(fetch_n), .int_ack_i(int_ack),
        .int_req_o(req), .vector_o(vec), .wait_ready_o(pin),
        .wait_ready_oe_o(oe), .ptr_o(ptr));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard, far above the few hundred cycles needed
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for a channel request
    task automatic wait_req(input int ch);
        for (int i = 0; i < 12 && req[ch] !== 1'b1; i++) step(1);
        check({7'h00, req[ch]}, 8'h01);
    endtask
    task automatic ack_clear(input int ch, input logic [7:0] e_vec);
        host.acknowledge(got);
        check(got, e_vec);
        step(2);
        check({7'h00, req[ch]}, 8'h00);
    endtask
    task automatic ctrl_b(input logic [7:0] c);
        host.write_reg(1'b0, SIVW_PTR_CTRL, c);
    endtask
    // transmit buffer empties on channel B
    task automatic tx_rise();
        txe[0] = 1'b0;
        step(4);
        txe[0] = 1'b1;
        wait_req(0);
    endtask
    task automatic t_pointer();
        host.put_byte(1'b0, {5'h00, SIVW_PTR_CTRL});
        host.put_byte(1'b0, 8'h00);
        check({5'h00, ptr}, {5'h00, SIVW_PTR_CTRL});
        host.release_bus();
        check({5'h00, ptr}, {5'h00, SIVW_PTR_CMD});
    endtask
    task automatic t_vector();
        host.write_reg(1'b0, SIVW_PTR_VEC, 8'hA5);
        host.write_reg(1'b1, SIVW_PTR_VEC, 8'h3C);
        step(2);
        check(vec, 8'hA5);
    endtask
    // status-affects-vector set only on channel A must not modify
    task automatic t_ext();
        ctrl_b(8'h00);
        host.write_reg(1'b1, SIVW_PTR_CTRL, 8'h05);
        ext_a[1] = 1'b1;
        wait_req(1);
        ack_clear(1, 8'hA5);
        ctrl_b(8'h04);
        for (int i = 0; i < 5; i++) begin
            ext_a[i] = ~ext_a[i];
            wait_req(1);
            ack_clear(1, 8'hAB);
        end
    endtask
    task automatic rx_spc(input logic [1:0] m, input int k, input logic sd,
                          input logic e);
        ctrl_b({3'h0, m, 3'h4});
        sdlc[0] = sd;
        spc_b[k] = 1'b1;
        step(6);
        check({7'h00, req[0]}, {7'h00, e});
        spc_b[k] = 1'b0;
        if (e) ack_clear(0, 8'hA7);
    endtask
    task automatic wr_case(input logic [7:0] c, input logic t, input logic r,
                           input logic s, input logic e_oe, input logic e_pin);
        ctrl_b(c);
        txe[0] = t;
        rxa[0] = r;
        sel[0] = s;
        step(4);
        check({7'h00, oe[0]}, {7'h00, e_oe});
        if (e_oe) check({7'h00, pin[0]}, {7'h00, e_pin});
    endtask
    initial begin
        step(8);
        check({4'h0, oe, pin}, 8'h03);
        check({6'h00, req}, 8'h00);
        rst_n_i = 1'b1;
        t_pointer();
        t_vector();
        ctrl_b(8'h06);
        tx_rise();
        ack_clear(0, 8'hA1);
        t_ext();
        rx_spc(SIVW_RXM_OFF, 1, 1'b0, 1'b0);
        rx_spc(SIVW_RXM_FIRST, 1, 1'b0, 1'b1);
        rx_spc(SIVW_RXM_ALL, 1, 1'b0, 1'b1);
        rx_spc(SIVW_RXM_NOPAR, 1, 1'b0, 1'b0);
        rx_spc(SIVW_RXM_NOPAR, 0, 1'b0, 1'b1);
        rx_spc(SIVW_RXM_NOPAR, 2, 1'b0, 1'b1);
        rx_spc(SIVW_RXM_ALL, 3, 1'b0, 1'b0);
        rx_spc(SIVW_RXM_ALL, 3, 1'b1, 1'b1);
        // every received character, cause code 010
        ctrl_b({3'h0, SIVW_RXM_ALL, 3'h4});
        rxa[0] = 1'b1;
        wait_req(0);
        ack_clear(0, 8'hA5);
        rxa[0] = 1'b0;
        // first-character mode: only a flagged first character counts
        ctrl_b({3'h0, SIVW_RXM_FIRST, 3'h4});
        rxa[0] = 1'b1;
        step(6);
        check({7'h00, req[0]}, 8'h00);
        rxa[0] = 1'b0;
        first[0] = 1'b1;
        step(2);
        rxa[0] = 1'b1;
        wait_req(0);
        ack_clear(0, 8'hA5);
        rxa[0] = 1'b0;
        first[0] = 1'b0;
        // wait/ready table: disabled, ready/wait on each buffer
        wr_case(8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        wr_case(8'hC0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        wr_case(8'hC0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        wr_case(8'h80, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        wr_case(8'h80, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        wr_case(8'h80, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        wr_case(8'hA0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        wr_case(8'hA0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        wr_case(8'hE0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        wr_case(8'hE0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        // acknowledge during opcode fetch must not clear the request
        ctrl_b(8'h02);
        tx_rise();
        host.set_fetch(1'b0);
        host.acknowledge(got);
        step(3);
        check({7'h00, req[0]}, 8'h01);
        host.set_fetch(1'b1);
        ack_clear(0, 8'hA5);
        // channel reset drops enables and the pending request
        ctrl_b(8'hC2);
        tx_rise();
        host.write_cmd(1'b0, {2'h0, SIVW_CMD_CHAN_RESET, 3'h0});
        step(2);
        check({4'h0, oe, req}, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
